/* ddr2_term_regs.svh */
// Register offsets, field positions, reset values and limits of the DDR2 command block
`ifndef DDR2_TERM_REGS_SVH
`define DDR2_TERM_REGS_SVH

`define CFG_OFS       12'h000
`define EXT_OFS       12'h004
`define STAT_OFS      12'h008
`define ROW_OFS       12'h00C

`define CFG_RST       14'h0032
`define EXT_RST       14'h0000

`define BLEN_MSB      2
`define BLEN_LSB      0
`define BTYPE_BIT     3
`define CAL_MSB       6
`define CAL_LSB       4
`define PD_MSB        5
`define PD_LSB        3
`define RTT_HI_BIT    6
`define RTT_LO_BIT    2

`define BLEN8_CODE    3'h3
`define PD_MAX        3'h4
`define CAL_MIN       3'h2
`define PIPE_DEPTH    12
`define COL_W         10
`define ROW_W         14

`endif

/* ddr2_term_pkg.sv */
// Types shared by the DDR2 command, burst and termination block
package ddr2_term_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  bank;
    logic [9:0]  col;
  } col_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  bank;
    logic [13:0] row;
  } act_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  bank;
    logic [9:0]  col_first;
    logic [9:0]  col_second;
  } beat_pair_t;

  typedef enum logic [1:0] {
    BURST_IDLE = 2'b01,
    BURST_RUN  = 2'b10
  } burst_state_t;

endpackage

/* ddr2_bank_burst_termination.sv */
// DDR2 command decode, posted column timing, burst ordering and termination switching
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "ddr2_term_regs.svh"

module ddr2_bank_burst_termination (
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [11:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      ck_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      ras_n_i,
  input  wire logic                      cas_n_i,
  input  wire logic                      we_n_i,
  input  wire logic [2:0]                bank_select_i,
  input  wire logic [13:0]               addr_i,
  input  wire logic                      termination_control_i,
  input  wire logic                      self_refresh_i,
  output logic      [2:0]                term_switch_o,
  output ddr2_term_pkg::act_cmd_t        act_o,
  output ddr2_term_pkg::col_cmd_t        col_issue_o,
  output ddr2_term_pkg::beat_pair_t      beat_o
);

  // Pin synchroniser: ck, control pins, bank, address, termination control
  localparam int PIN_W = 23;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic             ck_prev_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q   <= '1;
      sync2_q   <= '1;
      ck_prev_q <= 1'b1;
    end else begin
      sync1_q   <= {ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_select_i, addr_i,
                    termination_control_i};
      sync2_q   <= sync1_q;
      ck_prev_q <= sync2_q[PIN_W-1];
    end
  end

  logic        s_ck;
  logic        s_cs_n;
  logic        s_ras_n;
  logic        s_cas_n;
  logic        s_we_n;
  logic [2:0]  s_bank;
  logic [13:0] s_addr;
  logic        s_term;
  assign {s_ck, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr, s_term} = sync2_q;

  // Register file and APB slave state
  logic [13:0] cfg_q;
  logic [13:0] cfg_d;
  logic [13:0] ext_q;
  logic [13:0] ext_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // Command and burst state
  ddr2_term_pkg::col_cmd_t     pipe_q [`PIPE_DEPTH];
  ddr2_term_pkg::col_cmd_t     pipe_d [`PIPE_DEPTH];
  ddr2_term_pkg::col_cmd_t     bcmd_q;
  ddr2_term_pkg::col_cmd_t     bcmd_d;
  ddr2_term_pkg::act_cmd_t     act_q;
  ddr2_term_pkg::act_cmd_t     act_d;
  ddr2_term_pkg::col_cmd_t     issue_q;
  ddr2_term_pkg::col_cmd_t     issue_d;
  ddr2_term_pkg::beat_pair_t   beat_q;
  ddr2_term_pkg::beat_pair_t   beat_d;
  ddr2_term_pkg::burst_state_t bstate_q;
  ddr2_term_pkg::burst_state_t bstate_d;
  logic [2:0]                  bidx_q;
  logic [2:0]                  bidx_d;
  logic                        bl8_q;
  logic                        bl8_d;
  logic                        ilv_q;
  logic                        ilv_d;
  logic [2:0]                  term_q;
  logic [2:0]                  term_d;
  logic [2:0]                  last_bank_q;
  logic [2:0]                  last_bank_d;
  logic [13:0]                 last_row_q;
  logic [13:0]                 last_row_d;

  // Column address of one beat inside its aligned segment
  function automatic logic [9:0] beat_col(input logic [9:0] c, input logic [2:0] i,
                                           input logic bl8, input logic ilv);
    logic [2:0] lo;
    lo = 3'h0;
    if (ilv) begin
      lo = c[2:0] ^ i;
    end else begin
      lo[1:0] = c[1:0] + i[1:0];
      lo[2]   = c[2] ^ i[2];
    end
    if (!bl8) begin
      lo[2] = c[2];
    end
    beat_col = {c[9:3], lo};
  endfunction

  // Programmed fields
  logic        ck_rise;
  logic [2:0]  pdelay;
  logic [2:0]  cal;
  logic [3:0]  rdelay;
  logic [3:0]  pd_idx;
  logic [3:0]  rd_idx;
  logic [3:0]  wr_idx;
  logic        cfg_bl8;
  logic [1:0]  rtt_sel;

  assign ck_rise = s_ck & ~ck_prev_q;
  assign pdelay  = (ext_q[`PD_MSB:`PD_LSB] > `PD_MAX) ? `PD_MAX
                   : ext_q[`PD_MSB:`PD_LSB];
  assign cal     = (cfg_q[`CAL_MSB:`CAL_LSB] < `CAL_MIN) ? `CAL_MIN
                   : cfg_q[`CAL_MSB:`CAL_LSB];
  assign rdelay  = {1'b0, pdelay} + {1'b0, cal};
  assign pd_idx  = {1'b0, pdelay} - 4'h1;
  assign rd_idx  = rdelay - 4'h1;
  assign wr_idx  = rdelay - 4'h2;
  assign cfg_bl8 = (cfg_q[`BLEN_MSB:`BLEN_LSB] == `BLEN8_CODE);
  assign rtt_sel = {ext_q[`RTT_HI_BIT], ext_q[`RTT_LO_BIT]};

  always_comb begin
    ddr2_term_pkg::col_cmd_t new_cmd;
    ddr2_term_pkg::col_cmd_t start;
    logic                    is_act;
    logic                    last;
    new_cmd     = '0;
    start       = '0;
    is_act      = 1'b0;
    last        = 1'b0;
    pipe_d      = pipe_q;
    bcmd_d      = bcmd_q;
    act_d       = '0;
    issue_d     = '0;
    beat_d      = beat_q;
    bstate_d    = bstate_q;
    bidx_d      = bidx_q;
    bl8_d       = bl8_q;
    ilv_d       = ilv_q;
    last_bank_d = last_bank_q;
    last_row_d  = last_row_q;
    term_d      = 3'h0;
    // Only activate and column commands are decoded; any other code, burst stop
    // included, has no effect on a running burst.
    if (ck_rise && !s_cs_n) begin
      is_act            = !s_ras_n && s_cas_n && s_we_n;
      new_cmd.valid     = s_ras_n && !s_cas_n;
      new_cmd.write     = !s_we_n;
      new_cmd.bank      = s_bank;
      new_cmd.col       = s_addr[`COL_W-1:0];
    end
    if (is_act) begin
      act_d.valid = 1'b1;
      act_d.bank  = s_bank;
      act_d.row   = s_addr;
      last_bank_d = s_bank;
      last_row_d  = s_addr;
    end
    if (ck_rise) begin
      // Posted command leaves the delay line after the programmed clocks, capped at PD_MAX
      issue_d = (pdelay == 3'h0) ? new_cmd : pipe_q[pd_idx];
      pipe_d[0] = new_cmd;
      for (int k = 1; k < `PIPE_DEPTH; k++) begin
        pipe_d[k] = pipe_q[k-1];
      end
      if (pipe_q[rd_idx].valid && !pipe_q[rd_idx].write) begin
        start = pipe_q[rd_idx];
      end else if (pipe_q[wr_idx].valid && pipe_q[wr_idx].write) begin
        start = pipe_q[wr_idx];
      end
      beat_d = '0;
      if (start.valid) begin
        // A new burst takes over on the rise it starts, cutting short any running burst: no gap
        bcmd_d            = start;
        bl8_d             = cfg_bl8;
        ilv_d             = cfg_q[`BTYPE_BIT];
        beat_d.valid      = 1'b1;
        beat_d.write      = start.write;
        beat_d.bank       = start.bank;
        beat_d.col_first  = beat_col(start.col, 3'h0, cfg_bl8, cfg_q[`BTYPE_BIT]);
        beat_d.col_second = beat_col(start.col, 3'h1, cfg_bl8, cfg_q[`BTYPE_BIT]);
        bidx_d            = 3'h2;
        bstate_d          = ddr2_term_pkg::BURST_RUN;
      end else begin
        case (bstate_q)
          ddr2_term_pkg::BURST_RUN: begin
            last              = bl8_q ? (bidx_q == 3'h6) : (bidx_q == 3'h2);
            beat_d.valid      = 1'b1;
            beat_d.write      = bcmd_q.write;
            beat_d.bank       = bcmd_q.bank;
            beat_d.col_first  = beat_col(bcmd_q.col, bidx_q, bl8_q, ilv_q);
            beat_d.col_second = beat_col(bcmd_q.col, bidx_q + 3'h1, bl8_q, ilv_q);
            bidx_d            = bidx_q + 3'h2;
            if (last) begin
              bstate_d = ddr2_term_pkg::BURST_IDLE;
            end
          end
          default: begin
            bstate_d = ddr2_term_pkg::BURST_IDLE;
          end
        endcase
      end
    end
    // Termination switch set: enabled by control input, value picks the leg
    if (s_term && !self_refresh_i) begin
      case (rtt_sel)
        2'b01:   term_d = 3'b001;
        2'b10:   term_d = 3'b010;
        2'b11:   term_d = 3'b100;
        default: term_d = 3'b000;
      endcase
    end
  end

  // APB slave: data prepared in setup, answered in the first access cycle
  always_comb begin
    logic setup;
    logic wr_now;
    setup     = psel_i && !penable_i;
    wr_now    = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
    cfg_d     = cfg_q;
    ext_d     = ext_q;
    pready_d  = setup;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (setup) begin
      if (paddr_i == `CFG_OFS) begin
        prdata_d = {18'h0, cfg_q};
      end else if (paddr_i == `EXT_OFS) begin
        prdata_d = {18'h0, ext_q};
      end else if (paddr_i == `STAT_OFS) begin
        prdata_d = {25'h0, (bstate_q == ddr2_term_pkg::BURST_RUN) | beat_q.valid,
                    term_q, last_bank_q};
      end else if (paddr_i == `ROW_OFS) begin
        prdata_d = {18'h0, last_row_q};
      end else begin
        pslverr_d = 1'b1;
      end
      if (!pwrite_i) begin
        prdata_d = pslverr_d ? 32'h0000_0000 : prdata_d;
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (wr_now && paddr_i == `CFG_OFS) begin
      if (pstrb_i[0]) cfg_d[7:0]  = pwdata_i[7:0];
      if (pstrb_i[1]) cfg_d[13:8] = pwdata_i[13:8];
    end else if (wr_now && paddr_i == `EXT_OFS) begin
      if (pstrb_i[0]) ext_d[7:0]  = pwdata_i[7:0];
      if (pstrb_i[1]) ext_d[13:8] = pwdata_i[13:8];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q       <= `CFG_RST;
      ext_q       <= `EXT_RST;
      prdata_q    <= 32'h0000_0000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      for (int k = 0; k < `PIPE_DEPTH; k++) begin
        pipe_q[k] <= '0;
      end
      bcmd_q      <= '0;
      act_q       <= '0;
      issue_q     <= '0;
      beat_q      <= '0;
      bstate_q    <= ddr2_term_pkg::BURST_IDLE;
      bidx_q      <= 3'h0;
      bl8_q       <= 1'b0;
      ilv_q       <= 1'b0;
      term_q      <= 3'h0;
      last_bank_q <= 3'h0;
      last_row_q  <= 14'h0000;
    end else begin
      cfg_q       <= cfg_d;
      ext_q       <= ext_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      pipe_q      <= pipe_d;
      bcmd_q      <= bcmd_d;
      act_q       <= act_d;
      issue_q     <= issue_d;
      beat_q      <= beat_d;
      bstate_q    <= bstate_d;
      bidx_q      <= bidx_d;
      bl8_q       <= bl8_d;
      ilv_q       <= ilv_d;
      term_q      <= term_d;
      last_bank_q <= last_bank_d;
      last_row_q  <= last_row_d;
    end
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign term_switch_o = term_q;
  assign act_o         = act_q;
  assign col_issue_o   = issue_q;
  assign beat_o        = beat_q;

endmodule

/* ddr2_bank_burst_termination_asserts.sv */
// Port-level checks for the DDR2 command, burst and termination block
`timescale 1ns/10ps
module ddr2_bank_burst_termination_asserts (
  input wire logic                      clk_i,
  input wire logic                      nrst_i,
  input wire logic                      psel_i,
  input wire logic                      penable_i,
  input wire logic [31:0]               prdata_o,
  input wire logic                      pready_o,
  input wire logic                      pslverr_o,
  input wire logic                      termination_control_i,
  input wire logic                      self_refresh_i,
  input wire logic [2:0]                term_switch_o,
  input wire ddr2_term_pkg::act_cmd_t   act_o,
  input wire ddr2_term_pkg::col_cmd_t   col_issue_o,
  input wire ddr2_term_pkg::beat_pair_t beat_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error without ready or with data");
  a_sref_term_off: assert property (
    self_refresh_i && $past(self_refresh_i) |-> term_switch_o == 3'h0)
    else $error("termination on in self refresh");
  a_term_one_leg: assert property ($onehot0(term_switch_o))
    else $error("more than one termination leg");
  a_term_needs_ctl: assert property (
    !termination_control_i [*6] |-> term_switch_o == 3'h0)
    else $error("termination on without control");
  a_act_pulse: assert property (act_o.valid |=> !act_o.valid)
    else $error("activate pulse too long");
  a_col_pulse: assert property (col_issue_o.valid |=> !col_issue_o.valid)
    else $error("column issue pulse too long");
  a_beat_hold: assert property ($rose(beat_o.valid) |=> $stable(beat_o) [*4])
    else $error("beat pair not held");
  a_beat_pair_order: assert property (
    beat_o.valid |-> beat_o.col_first[9:2] == beat_o.col_second[9:2]
    && (beat_o.col_second[1:0] == beat_o.col_first[1:0] + 2'h1
    || beat_o.col_second[1:0] == (beat_o.col_first[1:0] ^ 2'h1)))
    else $error("beat pair out of order");
endmodule

bind ddr2_bank_burst_termination ddr2_bank_burst_termination_asserts u_chk (
  .clk_i, .nrst_i, .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o,
  .termination_control_i, .self_refresh_i, .term_switch_o, .act_o, .col_issue_o, .beat_o
);

/* ddr2_ctrl_model.sv */
// Memory controller model: free-running link clock and command pins
`timescale 1ns/10ps
module ddr2_ctrl_model (
  output logic        ck_o,
  output logic        cs_n_o,
  output logic        ras_n_o,
  output logic        cas_n_o,
  output logic        we_n_o,
  output logic [2:0]  bank_o,
  output logic [13:0] addr_o,
  output int          ck_cnt_o
);
  initial begin
    ck_o = 1'b0;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, bank_o, addr_o} = '1;
    #5;
    forever #24 ck_o = ~ck_o;
  end

  always @(posedge ck_o) ck_cnt_o <= ck_cnt_o + 1;

  // Pins change on the falling edge, centred on the sampling rise; n is that rise
  // Only activates and column commands are sent, at least two clocks apart
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
                     output int n);
    @(negedge ck_o);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, bank_o, addr_o} <= {1'b0, c, b, a};
    @(negedge ck_o);
    n = ck_cnt_o;
    // Deselected pins show the inverse, never the stale command
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, bank_o, addr_o} <= {1'b1, ~c, ~b, ~a};
  endtask
endmodule

/* ddr2_bank_burst_termination_tb.sv */
// Self-checking bench for the DDR2 command, burst and termination block
`timescale 1ns/10ps
module ddr2_bank_burst_termination_tb;
  typedef struct {int n; logic [9:0] a; logic [9:0] b; logic w; logic [2:0] bk;} pair_rec_t;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        tc = 1'b0;
  logic        sref = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, ck, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba, term;
  logic [13:0] ad;
  int          ck_cnt, acts = 0, err_total = 0, compares = 0;
  int          ci[$];
  pair_rec_t   q[$];
  ddr2_term_pkg::act_cmd_t   act, act_q;
  ddr2_term_pkg::col_cmd_t   col, col_l;
  ddr2_term_pkg::beat_pair_t beat;

  ddr2_bank_burst_termination uut (
    .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'hF),
    .prdata_o, .pready_o, .pslverr_o, .ck_i(ck), .cs_n_i(cs_n), .ras_n_i(ras_n),
    .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_i(ba), .addr_i(ad),
    .termination_control_i(tc), .self_refresh_i(sref), .term_switch_o(term),
    .act_o(act), .col_issue_o(col), .beat_o(beat));
  ddr2_ctrl_model m (.ck_o(ck), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n), .bank_o(ba), .addr_o(ad), .ck_cnt_o(ck_cnt));

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (col.valid === 1'b1) begin
    ci.push_back(ck_cnt);
    col_l <= col;
  end
  always @(posedge clk_i) if (act.valid === 1'b1) begin
    act_q <= act;
    acts <= acts + 1;
  end
  always @(negedge ck) if (beat.valid === 1'b1) q.push_back('{ck_cnt, beat.col_first,
    beat.col_second, beat.write, beat.bank});

  task automatic report_and_stop;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic ck_ok(input logic ok, input string s);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      ck_ok(1'b0, "bus timeout");
      report_and_stop();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function automatic logic [9:0] adr(logic [9:0] s, logic [2:0] i, logic b8, logic il);
    logic [2:0] x;
    x = il ? s[2:0] ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]};
    return b8 ? {s[9:3], x} : {s[9:2], x[1:0]};
  endfunction

  task automatic expect_burst(input int n, input logic [9:0] s, input logic b8,
                              input logic il, input logic w);
    pair_rec_t p;
    logic      ok;
    for (int k = 0; k < (b8 ? 4 : 2); k++) begin
      p = '{-1, 10'h0, 10'h0, 1'b0, 3'h0};
      if (q.size() > 0) begin
        p = q.pop_front();
      end
      ok = p.n == n + k && p.a === adr(s, 3'(2 * k), b8, il) && p.w === w;
      ok = ok && p.b === adr(s, 3'(2 * k + 1), b8, il) && p.bk === 3'h5;
      ck_ok(ok, "burst beat");
    end
  endtask

  task automatic burst(input logic w, input logic [9:0] c, input logic b8, input logic il,
                       input int al, input int cl);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, 12'h000, {25'h0, 3'(cl), il, b8 ? 3'h3 : 3'h2}, r, e);
    apb(1'b1, 12'h004, 32'(al) << 3, r, e);
    ci.delete();
    m.cmd({2'b10, ~w}, 3'h5, {4'h0, c}, n);
    repeat (al + cl + 6) @(negedge ck);
    ck_ok(ci.size() == 1 && ci[0] == n + al, "posted issue");
    ck_ok(col_l === {1'b1, w, 3'h5, c}, "issued command");
    expect_burst(n + al + cl - w, c, b8, il, w);
    ck_ok(q.size() == 0, "extra beats");
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    int          n;
    int          n2;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, r, e);
    ck_ok(r === 32'h32 && e === 1'b0, "config reset");
    apb(1'b0, 12'h004, 32'h0, r, e);
    ck_ok(r === 32'h0, "extended reset");
    apb(1'b0, 12'h010, 32'h0, r, e);
    ck_ok(e === 1'b1 && r === 32'h0, "unmapped access");
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, 12'h004, {25'h0, v[1], 3'h0, v[0], 2'h0}, r, e);
      tc <= 1'b1;
      repeat (6) @(posedge clk_i);
      ck_ok(term === (v == 0 ? 3'h0 : 3'h1 << (v - 1)), "termination leg");
    end
    sref <= 1'b1;
    repeat (3) @(posedge clk_i);
    ck_ok(term === 3'h0, "self refresh termination");
    sref <= 1'b0;
    tc <= 1'b0;
    repeat (6) @(posedge clk_i);
    ck_ok(term === 3'h0, "control low termination");
    m.cmd(3'b011, 3'h5, 14'h2A5C, n);
    repeat (3) @(negedge ck);
    ck_ok(acts == 1 && act_q === {1'b1, 3'h5, 14'h2A5C}, "activate");
    apb(1'b0, 12'h00C, 32'h0, r, e);
    ck_ok(r === 32'h2A5C && e === 1'b0, "activated row");
    apb(1'b0, 12'h008, 32'h0, r, e);
    ck_ok(r === 32'h5 && e === 1'b0, "status after activate");
    for (int i = 0; i < 8; i++) burst(i[0], 10'(i * 37 + 1), i[2], i[1], i % 5, 2 + i % 3);
    apb(1'b1, 12'h000, 32'h32, r, e);
    apb(1'b1, 12'h004, 32'h10, r, e);
    m.cmd(3'b101, 3'h5, 14'h0006, n);
    m.cmd(3'b101, 3'h5, 14'h000B, n2);
    repeat (10) @(negedge ck);
    expect_burst(n + 5, 10'h006, 1'b0, 1'b0, 1'b0);
    expect_burst(n + 7, 10'h00B, 1'b0, 1'b0, 1'b0);
    ck_ok(q.size() == 0, "extra beats");
    ck_ok(acts == 1, "no stray activate");
    report_and_stop();
  end
endmodule
